// ===== dbu_params.svh
// register offsets, field positions, codes and baud and framing constants of the port
`ifndef DBU_PARAMS_SVH
`define DBU_PARAMS_SVH

// register byte offsets
`define DBU_OFF_CTRL 8'h00
`define DBU_OFF_MODE 8'h04
`define DBU_OFF_IEN_SET 8'h08
`define DBU_OFF_IEN_CLR 8'h0C
`define DBU_OFF_IEN_VIEW 8'h10
`define DBU_OFF_STATUS 8'h14
`define DBU_OFF_RX_HOLD 8'h18
`define DBU_OFF_TX_HOLD 8'h1C
`define DBU_OFF_BAUD 8'h20

// control command bits
`define DBU_C_RX_RESET 2
`define DBU_C_TX_RESET 3
`define DBU_C_RX_ON 4
`define DBU_C_RX_OFF 5
`define DBU_C_TX_ON 6
`define DBU_C_TX_OFF 7
`define DBU_C_CLEAR_ERRORS 8

// mode fields
`define DBU_F_CHECK_LSB 9
`define DBU_F_CHAN_LSB 14
`define DBU_CHECK_EVEN 3'h0
`define DBU_CHECK_ODD 3'h1
`define DBU_CHECK_SPACE 3'h2
`define DBU_CHECK_MARK 3'h3
`define DBU_CHECK_NONE_BIT 2
`define DBU_CH_NORMAL 2'h0
`define DBU_CH_ECHO 2'h1
`define DBU_CH_LOCAL 2'h2
`define DBU_CH_REMOTE 2'h3

// shared status / enable layout
`define DBU_B_RX_CHAR_READY 0
`define DBU_B_TX_HOLDING_FREE 1
`define DBU_B_RX_TRANSFER_END 3
`define DBU_B_TX_TRANSFER_END 4
`define DBU_B_OVERRUN 5
`define DBU_B_FRAMING 6
`define DBU_B_CHECK_BIT_ERROR 7
`define DBU_B_TX_FULLY_IDLE 9
`define DBU_B_TX_BUFFER_DRAINED 11
`define DBU_B_RX_BUFFER_FILLED 12
`define DBU_B_DBG_WRITE 30
`define DBU_B_DBG_READ 31
`define DBU_IRQ_VALID 32'hC0001AFB

// baud generation and character framing
`define DBU_OVS_SHIFT 4'h4
`define DBU_LAST_DATA_BIT 3'h7
`define DBU_CD_OFF 16'h0000
`define DBU_CD_DIRECT 16'h0001
`define DBU_CNT_ONE 20'h00001

`endif

// ===== dbu_pkg.sv
// types shared by the debug serial port
package dbu_pkg;

    // character framing phases, one-hot
    typedef enum logic [4:0] {
        DBU_IDLE = 5'b00001,
        DBU_START = 5'b00010,
        DBU_DATA = 5'b00100,
        DBU_PARITY = 5'b01000,
        DBU_STOP = 5'b10000
    } dbu_phase_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } dbu_apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dbu_apb_rsp_t;

    // levels mirrored from block transfer and debug channels
    typedef struct packed {
        logic rx_transfer_end;
        logic tx_transfer_end;
        logic tx_buffer_drained;
        logic rx_buffer_filled;
        logic debug_chan_write_pending;
        logic debug_chan_read_pending;
    } dbu_side_t;

    // whole state of the port
    typedef struct packed {
        dbu_apb_rsp_t rsp;
        logic [2:0] check_bit_kind;
        logic [1:0] channel_mode;
        logic [15:0] baud_divisor;
        logic [31:0] imr;
        logic rx_en;
        logic tx_en;
        logic rx_ready;
        logic ovr;
        logic frm;
        logic par_err;
        logic [7:0] rhr;
        logic [7:0] thr;
        logic thr_full;
        dbu_phase_t tx_st;
        logic [19:0] tx_cnt;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic tx_line;
        dbu_phase_t rx_st;
        logic [19:0] rx_cnt;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_par;
        logic rx_s1;
        logic rx_s2;
        logic pin;
        logic irq;
    } dbu_state_t;

endpackage

// ===== dbu_uart.sv
// debug serial port: apb registers, baud generator, transmitter, receiver
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "dbu_params.svh"

module dbu_uart (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // apb slave
    input dbu_pkg::dbu_apb_req_t apb_req,
    output dbu_pkg::dbu_apb_rsp_t apb_rsp,
    // mirrored channel levels
    input dbu_pkg::dbu_side_t side,
    // serial line
    input wire logic debug_rx_pin,
    output logic debug_tx_pin,
    // interrupt
    output logic irq
);
    import dbu_pkg::*;

    dbu_state_t st;
    dbu_state_t nxt;
    logic [31:0] sr;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic bus_wr;
    logic bus_rd;
    logic tx_run;
    logic rx_run;
    logic tx_tick;
    logic rx_tick;
    logic rx_in;
    logic [19:0] period;

    // ************************************************************
    // helpers
    // ************************************************************

    // clocks per bit: master_clock itself at 1, else 16 per divisor step
    function automatic logic [19:0] bit_period(input logic [15:0] cd);
        if (cd == `DBU_CD_DIRECT)
            bit_period = `DBU_CNT_ONE;
        else
            bit_period = {cd, 4'h0} ;
    endfunction

    // check bit sent and expected for a data byte
    function automatic logic check_bit(input logic [2:0] kind,
                                       input logic [7:0] d);
        case (kind)
            `DBU_CHECK_EVEN: check_bit = ^d;
            `DBU_CHECK_ODD: check_bit = ~^d;
            `DBU_CHECK_SPACE: check_bit = 1'b0;
            `DBU_CHECK_MARK: check_bit = 1'b1;
            default: check_bit = 1'b0;
        endcase
    endfunction

    // ************************************************************
    // decode and status
    // ************************************************************

    // a transfer completes at the edge where pready is seen high
    assign bus_wr = apb_req.psel & apb_req.penable & st.rsp.pready &
                    apb_req.pwrite;
    assign bus_rd = apb_req.psel & apb_req.penable & st.rsp.pready &
                    ~apb_req.pwrite;
    // remote loopback keeps both ends out of the way
    assign tx_run = st.tx_en & (st.channel_mode != `DBU_CH_REMOTE);
    assign rx_run = st.rx_en & (st.channel_mode != `DBU_CH_REMOTE);
    assign period = bit_period(st.baud_divisor);
    // a zero divisor freezes both bit counters
    assign tx_tick = (st.tx_cnt == 20'h0) &
                     (st.baud_divisor != `DBU_CD_OFF);
    assign rx_tick = (st.rx_cnt == 20'h0) &
                     (st.baud_divisor != `DBU_CD_OFF);
    // local loopback hears only its own transmitter
    assign rx_in = (st.channel_mode == `DBU_CH_LOCAL) ? st.tx_line :
                   st.rx_s2;

    // status word, same layout as the enable registers
    always_comb
    begin
        sr = 32'h0;
        sr[`DBU_B_RX_CHAR_READY] = st.rx_ready;
        sr[`DBU_B_TX_HOLDING_FREE] = st.tx_en & ~st.thr_full;
        sr[`DBU_B_RX_TRANSFER_END] = side.rx_transfer_end;
        sr[`DBU_B_TX_TRANSFER_END] = side.tx_transfer_end;
        sr[`DBU_B_OVERRUN] = st.ovr;
        sr[`DBU_B_FRAMING] = st.frm;
        sr[`DBU_B_CHECK_BIT_ERROR] = st.par_err;
        sr[`DBU_B_TX_FULLY_IDLE] = st.tx_en & ~st.thr_full &
                                   (st.tx_st == DBU_IDLE);
        sr[`DBU_B_TX_BUFFER_DRAINED] = side.tx_buffer_drained;
        sr[`DBU_B_RX_BUFFER_FILLED] = side.rx_buffer_filled;
        sr[`DBU_B_DBG_WRITE] = side.debug_chan_write_pending;
        sr[`DBU_B_DBG_READ] = side.debug_chan_read_pending;
    end

    // read multiplexer; write-only registers read zero
    always_comb
    begin
        rd_mux = 32'h0;
        rd_hit = 1'b1;
        case (apb_req.paddr)
            `DBU_OFF_MODE:
            begin
                rd_mux[`DBU_F_CHECK_LSB +: 3] = st.check_bit_kind;
                rd_mux[`DBU_F_CHAN_LSB +: 2] = st.channel_mode;
            end
            `DBU_OFF_IEN_VIEW: rd_mux = st.imr;
            `DBU_OFF_STATUS: rd_mux = sr;
            `DBU_OFF_RX_HOLD: rd_mux[7:0] = st.rhr;
            `DBU_OFF_BAUD: rd_mux[15:0] = st.baud_divisor;
            `DBU_OFF_CTRL, `DBU_OFF_IEN_SET, `DBU_OFF_IEN_CLR,
            `DBU_OFF_TX_HOLD: rd_mux = 32'h0;
            default: rd_hit = 1'b0;
        endcase
    end

    // ************************************************************
    // next state
    // ************************************************************

    always_comb
    begin
        nxt = st;
        // apb answer one cycle into the access phase, with data
        nxt.rsp.pready = apb_req.psel & apb_req.penable & ~st.rsp.pready;
        nxt.rsp.prdata = nxt.rsp.pready ? rd_mux : 32'h0;
        nxt.rsp.pslverr = nxt.rsp.pready & ~rd_hit;

        // register writes; clears come before the events that set
        if (bus_wr)
        begin
            case (apb_req.paddr)
                `DBU_OFF_CTRL:
                begin
                    if (apb_req.pwdata[`DBU_C_RX_ON] &
                        ~apb_req.pwdata[`DBU_C_RX_OFF])
                        nxt.rx_en = 1'b1;
                    if (apb_req.pwdata[`DBU_C_RX_OFF])
                        nxt.rx_en = 1'b0;
                    if (apb_req.pwdata[`DBU_C_TX_ON] &
                        ~apb_req.pwdata[`DBU_C_TX_OFF])
                        nxt.tx_en = 1'b1;
                    if (apb_req.pwdata[`DBU_C_TX_OFF])
                        nxt.tx_en = 1'b0;
                    // resets abort the character in flight unless a bit tick steps its phase in that same cycle
                    if (apb_req.pwdata[`DBU_C_RX_RESET])
                    begin
                        nxt.rx_en = 1'b0;
                        nxt.rx_st = DBU_IDLE;
                    end
                    if (apb_req.pwdata[`DBU_C_TX_RESET])
                    begin
                        nxt.tx_en = 1'b0;
                        nxt.tx_st = DBU_IDLE;
                        nxt.thr_full = 1'b0;
                        nxt.tx_line = 1'b1;
                    end
                    if (apb_req.pwdata[`DBU_C_CLEAR_ERRORS])
                    begin
                        nxt.ovr = 1'b0;
                        nxt.frm = 1'b0;
                        nxt.par_err = 1'b0;
                    end
                end
                `DBU_OFF_MODE:
                begin
                    nxt.check_bit_kind =
                        apb_req.pwdata[`DBU_F_CHECK_LSB +: 3];
                    nxt.channel_mode =
                        apb_req.pwdata[`DBU_F_CHAN_LSB +: 2];
                end
                `DBU_OFF_IEN_SET: nxt.imr = st.imr |
                    (apb_req.pwdata & `DBU_IRQ_VALID);
                `DBU_OFF_IEN_CLR: nxt.imr = st.imr &
                    ~(apb_req.pwdata & `DBU_IRQ_VALID);
                `DBU_OFF_BAUD: nxt.baud_divisor = apb_req.pwdata[15:0];
                default: nxt.imr = st.imr;
            endcase
        end
        // reading the holding register or disabling drops the flag
        if ((bus_rd && apb_req.paddr == `DBU_OFF_RX_HOLD) || !st.rx_en)
            nxt.rx_ready = 1'b0;

        // transmitter: one bit counter doubles as the baud divider
        if (st.tx_st != DBU_IDLE && st.baud_divisor != `DBU_CD_OFF)
            nxt.tx_cnt = tx_tick ? period - `DBU_CNT_ONE :
                         st.tx_cnt - `DBU_CNT_ONE;
        case (st.tx_st)
            DBU_IDLE:
            begin
                // the waiting byte moves to the shifter when free
                if (tx_run && st.thr_full)
                begin
                    nxt.tx_sh = st.thr;
                    nxt.thr_full = 1'b0;
                    nxt.tx_par = check_bit(st.check_bit_kind, st.thr);
                    nxt.tx_line = 1'b0;
                    nxt.tx_cnt = period - `DBU_CNT_ONE;
                    nxt.tx_st = DBU_START;
                end
            end
            DBU_START:
                if (tx_tick)
                begin
                    nxt.tx_line = st.tx_sh[0];
                    nxt.tx_sh = {1'b0, st.tx_sh[7:1]};
                    nxt.tx_bit = 3'h0;
                    nxt.tx_st = DBU_DATA;
                end
            DBU_DATA:
                if (tx_tick)
                begin
                    if (st.tx_bit == `DBU_LAST_DATA_BIT)
                    begin
                        // top bit of the kind drops the check bit
                        if (st.check_bit_kind[`DBU_CHECK_NONE_BIT])
                        begin
                            nxt.tx_line = 1'b1;
                            nxt.tx_st = DBU_STOP;
                        end
                        else
                        begin
                            nxt.tx_line = st.tx_par;
                            nxt.tx_st = DBU_PARITY;
                        end
                    end
                    else
                    begin
                        nxt.tx_line = st.tx_sh[0];
                        nxt.tx_sh = {1'b0, st.tx_sh[7:1]};
                        nxt.tx_bit = st.tx_bit + 3'h1;
                    end
                end
            DBU_PARITY:
                if (tx_tick)
                begin
                    nxt.tx_line = 1'b1;
                    nxt.tx_st = DBU_STOP;
                end
            DBU_STOP:
                if (tx_tick)
                    nxt.tx_st = DBU_IDLE;
            default: nxt.tx_st = DBU_IDLE;
        endcase

        // receiver: sample each bit in its middle
        if (st.rx_st != DBU_IDLE && st.baud_divisor != `DBU_CD_OFF)
            nxt.rx_cnt = rx_tick ? period - `DBU_CNT_ONE :
                         st.rx_cnt - `DBU_CNT_ONE;
        case (st.rx_st)
            DBU_IDLE:
                if (rx_run && !rx_in &&
                    st.baud_divisor != `DBU_CD_OFF)
                begin
                    // at one clock a bit the start level is already mid-bit
                    nxt.rx_cnt = {1'b0, period[19:1]};
                    nxt.rx_bit = 3'h0;
                    nxt.rx_st = (period == `DBU_CNT_ONE) ? DBU_DATA :
                                DBU_START;
                end
            DBU_START:
                if (rx_tick)
                begin
                    // a start bit gone high by mid-bit was a glitch
                    nxt.rx_bit = 3'h0;
                    nxt.rx_st = rx_in ? DBU_IDLE : DBU_DATA;
                end
            DBU_DATA:
                if (rx_tick)
                begin
                    nxt.rx_sh = {rx_in, st.rx_sh[7:1]};
                    nxt.rx_bit = st.rx_bit + 3'h1;
                    if (st.rx_bit == `DBU_LAST_DATA_BIT)
                        nxt.rx_st =
                            st.check_bit_kind[`DBU_CHECK_NONE_BIT] ?
                            DBU_STOP : DBU_PARITY;
                end
            DBU_PARITY:
                if (rx_tick)
                begin
                    nxt.rx_par = rx_in;
                    nxt.rx_st = DBU_STOP;
                end
            DBU_STOP:
                if (rx_tick)
                begin
                    // the set of every flag wins over its clear
                    nxt.rx_st = DBU_IDLE;
                    nxt.rhr = st.rx_sh;
                    nxt.rx_ready = 1'b1;
                    if (st.rx_ready)
                        nxt.ovr = 1'b1;
                    if (!rx_in)
                        nxt.frm = 1'b1;
                    if (!st.check_bit_kind[`DBU_CHECK_NONE_BIT] &&
                        st.rx_par !=
                        check_bit(st.check_bit_kind, st.rx_sh))
                        nxt.par_err = 1'b1;
                end
            default: nxt.rx_st = DBU_IDLE;
        endcase

        // a new byte replaces one still waiting; after the shifter load
        if (bus_wr && apb_req.paddr == `DBU_OFF_TX_HOLD)
        begin
            nxt.thr = apb_req.pwdata[7:0];
            nxt.thr_full = 1'b1;
        end

        // pin synchroniser; first stage feeds only the second
        nxt.rx_s1 = debug_rx_pin;
        nxt.rx_s2 = st.rx_s1;
        // line driver per channel mode
        case (st.channel_mode)
            `DBU_CH_NORMAL: nxt.pin = st.tx_line;
            `DBU_CH_ECHO: nxt.pin = st.rx_s2;
            `DBU_CH_LOCAL: nxt.pin = 1'b1;
            `DBU_CH_REMOTE: nxt.pin = st.rx_s2;
            default: nxt.pin = 1'b1;
        endcase
        nxt.irq = |(sr & st.imr);
    end

    // ************************************************************
    // state register
    // ************************************************************

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            st <= '0;
            st.tx_st <= DBU_IDLE;
            st.rx_st <= DBU_IDLE;
            st.tx_line <= 1'b1;
            st.rx_s1 <= 1'b1;
            st.rx_s2 <= 1'b1;
            st.pin <= 1'b1;
        end
        else
            st <= nxt;
    end

    assign apb_rsp = st.rsp;
    assign debug_tx_pin = st.pin;
    assign irq = st.irq;

    // ************************************************************
    // checks
    // ************************************************************

    a_ien_set_bits: assert property (
        @(posedge clock) disable iff (!reset_n)
        bus_wr && apb_req.paddr == `DBU_OFF_IEN_SET |=>
        (st.imr & $past(apb_req.pwdata) & `DBU_IRQ_VALID) ==
        ($past(apb_req.pwdata) & `DBU_IRQ_VALID))
        else $error("enable set did not take");

    a_ien_clr_bits: assert property (
        @(posedge clock) disable iff (!reset_n)
        bus_wr && apb_req.paddr == `DBU_OFF_IEN_CLR |=>
        (st.imr & $past(apb_req.pwdata)) == 32'h0)
        else $error("enable clear did not take");

    a_mask_view_read: assert property (
        @(posedge clock) disable iff (!reset_n)
        bus_rd && apb_req.paddr == `DBU_OFF_IEN_VIEW |->
        apb_rsp.prdata == st.imr)
        else $error("mask view mismatch");

    a_error_flag_sticky: assert property (
        @(posedge clock) disable iff (!reset_n)
        st.ovr && !(bus_wr && apb_req.paddr == `DBU_OFF_CTRL) |=> st.ovr)
        else $error("overrun flag dropped");

    a_clear_errors_cmd: assert property (
        @(posedge clock) disable iff (!reset_n)
        bus_wr && apb_req.paddr == `DBU_OFF_CTRL &&
        apb_req.pwdata[`DBU_C_CLEAR_ERRORS] && st.rx_st != DBU_STOP |=>
        !st.ovr && !st.frm && !st.par_err)
        else $error("error flags not cleared");

    a_tx_off_status: assert property (
        @(posedge clock) disable iff (!reset_n)
        !st.tx_en |-> !sr[`DBU_B_TX_HOLDING_FREE] &&
        !sr[`DBU_B_TX_FULLY_IDLE])
        else $error("tx status while disabled");

    a_local_line_high: assert property (
        @(posedge clock) disable iff (!reset_n)
        st.channel_mode == `DBU_CH_LOCAL ##1
        st.channel_mode == `DBU_CH_LOCAL |-> debug_tx_pin)
        else $error("line not idle in local loop");

    a_remote_follows: assert property (
        @(posedge clock) disable iff (!reset_n)
        st.channel_mode == `DBU_CH_REMOTE |=>
        debug_tx_pin == $past(st.rx_s2))
        else $error("remote loop not followed");

    a_irq_from_mask: assert property (
        @(posedge clock) disable iff (!reset_n)
        (st.rx_ready && st.imr[`DBU_B_RX_CHAR_READY]) ||
        (st.ovr && st.imr[`DBU_B_OVERRUN]) ||
        (side.debug_chan_write_pending && st.imr[`DBU_B_DBG_WRITE])
        |=> irq)
        else $error("interrupt output wrong");

    a_irq_all_masked: assert property (
        @(posedge clock) disable iff (!reset_n)
        st.imr == 32'h0 |=> !irq)
        else $error("interrupt while all masked");

endmodule

// ===== dbu_term.sv
// serial terminal model that faces the debug port pins
`timescale 1ns/10ps
module dbu_term #(
    parameter int BIT_CYC = 32
) (
    // clock
    input wire logic clock,
    // serial line
    input wire logic tx_pin,
    output logic rx_pin
);
    logic [31:0] q [$];
    logic [7:0] b;

    initial rx_pin = 1'b1;

    // one bit period on the line
    task automatic put(input logic v);
        rx_pin <= v;
        repeat (BIT_CYC) @(posedge clock);
    endtask

    // frame: start, lsb first, optional check bit, stop, one idle bit
    task automatic send(input logic [7:0] d, input logic pe,
                        input logic pb, input logic sb);
        put(1'b0);
        for (int i = 0; i < 8; i++)
            put(d[i]);
        if (pe)
            put(pb);
        put(sb);
        put(1'b1);
    endtask

    // raw level for the pin-path tests
    task automatic hold(input logic v);
        @(posedge clock);
        rx_pin <= v;
    endtask

    // sample mid-bit; a glitch still yields a byte, so tests check order
    always
    begin
        @(negedge tx_pin);
        repeat (BIT_CYC / 2) @(posedge clock);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYC) @(posedge clock);
            b[i] = tx_pin;
        end
        q.push_back({24'h0, b});
        repeat (BIT_CYC) @(posedge clock);
    end
endmodule

// ===== debug_uart_register_interface_tb.sv
// self-checking bench for the debug serial port
`timescale 1ns/10ps
module debug_uart_register_interface_tb;
    import dbu_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    dbu_apb_req_t req = '0;
    dbu_apb_rsp_t rsp;
    dbu_side_t side = '0;
    logic rx_pin;
    logic tx_pin;
    logic irq;
    logic [31:0] rd;
    logic er;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    int k;
    // write addr, write data, read addr, expected read
    logic [79:0] rows [7] = '{
        {8'h04, 32'hFFFFFFFF, 8'h04, 32'h0000CE00},
        {8'h04, 32'h00000600, 8'h04, 32'h00000600},
        {8'h20, 32'hFFFF1234, 8'h20, 32'h00001234},
        {8'h08, 32'hFFFFFFFF, 8'h10, 32'hC0001AFB},
        {8'h0C, 32'h40000001, 8'h10, 32'h80001AFA},
        {8'h10, 32'hFFFFFFFF, 8'h10, 32'h80001AFA},
        {8'h0C, 32'hFFFFFFFF, 8'h10, 32'h00000000}
    };

    always #12.5 clock = ~clock;

    dbu_uart u_dut (.clock(clock), .reset_n(reset_n), .apb_req(req),
        .apb_rsp(rsp), .side(side), .debug_rx_pin(rx_pin),
        .debug_tx_pin(tx_pin), .irq(irq));
    // divisor 2 below gives 16 * 2 clocks a bit
    dbu_term #(.BIT_CYC(32)) u_term (.clock(clock), .tx_pin(tx_pin),
        .rx_pin(rx_pin));

    task summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_fail++;
            summarize();
        end
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock);
        req.penable <= 1'b1;
        do
            @(posedge clock);
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req <= '0;
    endtask

    // ********************
    // main sequence
    // ********************
    initial
    begin
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        apb(1'b0, 8'h14, 0);
        chk(rd, 0);
        apb(1'b0, 8'h24, 0);
        chk({31'h0, er}, 1);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i][79:72], rows[i][71:40]);
            apb(1'b0, rows[i][39:32], 0);
            chk(rd, rows[i][31:0]);
        end
        side <= '1;
        apb(1'b0, 8'h14, 0);
        chk(rd, 32'hC0001818);
        apb(1'b1, 8'h08, 32'h40000000);
        repeat (2) @(negedge clock);
        chk({31'h0, irq}, 1);
        @(posedge clock);
        side <= '0;
        repeat (3) @(negedge clock);
        chk({31'h0, irq}, 0);
        $display("registers and mirrors done");
        apb(1'b1, 8'h20, 2);
        apb(1'b1, 8'h04, 32'h800);
        apb(1'b1, 8'h00, 32'h50);
        apb(1'b0, 8'h14, 0);
        chk(rd, 32'h202);
        // back to back: the second byte must wait behind the first
        apb(1'b1, 8'h1C, 32'hA5);
        apb(1'b1, 8'h1C, 32'h3C);
        apb(1'b0, 8'h14, 0);
        chk(rd, 0);
        k = 0;
        while (u_term.q.size() < 2 && k < 2000)
        begin
            @(posedge clock);
            k++;
        end
        chk(u_term.q[0], 32'hA5);
        chk(u_term.q[1], 32'h3C);
        repeat (64) @(posedge clock);
        apb(1'b0, 8'h14, 0);
        chk(rd, 32'h202);
        $display("transmit done");
        for (k = 0; k < 5; k++)
        begin
            apb(1'b1, 8'h04, k << 9);
            u_term.send(8'h81, k < 4, (k < 2) ? (^8'h81 ^ k[0]) : k[0], 1);
            apb(1'b0, 8'h14, 0);
            chk(rd, 32'h203);
            apb(1'b0, 8'h18, 0);
            chk(rd, 32'h81);
            apb(1'b0, 8'h14, 0);
            chk(rd, 32'h202);
        end
        // wrong check bit, then a byte on top of an unread one
        apb(1'b1, 8'h04, 0);
        u_term.send(8'h81, 1'b1, 1'b1, 1'b1);
        u_term.send(8'h81, 1'b1, 1'b0, 1'b1);
        apb(1'b0, 8'h14, 0);
        chk(rd, 32'h2A3);
        u_term.send(8'h00, 1'b1, 1'b0, 1'b0);
        apb(1'b0, 8'h14, 0);
        chk(rd, 32'h2E3);
        apb(1'b0, 8'h18, 0);
        apb(1'b1, 8'h00, 32'h100);
        apb(1'b0, 8'h14, 0);
        chk(rd, 32'h202);
        $display("receive done");
        for (k = 1; k < 4; k++)
        begin
            apb(1'b1, 8'h04, 32'h800 | (k << 14));
            u_term.hold(1'b0);
            repeat (8) @(posedge clock);
            chk({31'h0, tx_pin}, k == 2);
            u_term.hold(1'b1);
            repeat (8) @(posedge clock);
        end
        $display("pin paths done");
        // one clock a bit in local loopback, then a stopped baud clock
        apb(1'b1, 8'h20, 1);
        apb(1'b1, 8'h04, 32'h8800);
        apb(1'b1, 8'h1C, 32'h5A);
        repeat (20) @(posedge clock);
        apb(1'b0, 8'h14, 0);
        chk(rd, 32'h203);
        apb(1'b0, 8'h18, 0);
        chk(rd, 32'h5A);
        apb(1'b1, 8'h20, 0);
        apb(1'b1, 8'h1C, 32'h77);
        repeat (40) @(posedge clock);
        apb(1'b0, 8'h14, 0);
        chk(rd, 32'h2);
        $display("baud limits done");
        // mid-run reset clears the registers and idles the line
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        chk({31'h0, tx_pin}, 1);
        apb(1'b0, 8'h04, 0);
        chk(rd, 0);
        apb(1'b0, 8'h14, 0);
        chk(rd, 0);
        $display("reset done");
        summarize();
    end
endmodule
